/* pkg/etc_params.svh */
// constants, register map and rule notes for exposure trigger control
// Notes on behaviour
// R1 - trigger edges accepted only when enable is 1
// R2 - polarity 0 falling edge, 1 rising edge
// R3 - style 0 programmable, 1 level controlled
// R4 - source field picks one of four inputs
// R5 - source defaults to input port 0
// R6 - edges start exposure only while armed
// R7 - single arm plus edge captures one image
// R8 - single arm self clears after transmission
// R9 - repeat arm starts exposure every edge
// R10 - writing repeat arm 0 stops captures
// R11 - source waits for ready high before edge
// R12 - programmable exposure lasts shutter time then readout
// R13 - exposure active high during exposure
// R14 - exposure active defaults to output port 0
// R15 - exposure active output port is remappable
// R16 - new exposure may overlap previous readout
// R17 - exposure active may lag real exposure
// R18 - level mode lasts to opposite edge, shutter minimum
// R19 - ready falls at start, rises when safe
// R20 - edges while ready low are ignored
// R21 - trigger input synchronised by two flops
// R22 - config writes affect only later exposures; code latches only style and polarity, shutter time and port map act at once
`ifndef ETC_PARAMS_SVH
`define ETC_PARAMS_SVH
`define ETC_OFS_CTRL 4'h0
`define ETC_OFS_ARM 4'h4
`define ETC_OFS_SHUT 4'h8
`define ETC_OFS_STAT 4'hc
`define ETC_B_EN 0
`define ETC_B_POL 1
`define ETC_B_STYLE 2
`define ETC_B_SRC 4
`define ETC_B_OMAP 8
`define ETC_B_SINGLE 0
`define ETC_B_REPEAT 1
`define ETC_CTRL_RST 32'h0000_0000
`define ETC_SHUT_RST 32'h0000_0064
`define ETC_CLK_MHZ 25
`define ETC_LAG_NS 200
`define ETC_LAG_CYC ((`ETC_LAG_NS * `ETC_CLK_MHZ + 999) / 1000)
`define ETC_READOUT_CYC 2000
`define ETC_XMIT_CYC 3000
`endif

/* pkg/etc_pkg.sv */
// types for exposure trigger control
package etc_pkg;
  typedef enum logic [1:0] {
    ETC_IDLE = 2'b00,
    ETC_PROG = 2'b01,
    ETC_LEVEL = 2'b10
  } etc_exp_t;
endpackage

/* rtl/etc_top.sv */
// exposure start control with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "etc_params.svh"
module etc_top
  import etc_pkg::*;
#(
  parameter int READOUT_CYC = `ETC_READOUT_CYC,
  parameter int XMIT_CYC = `ETC_XMIT_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [3:0] ext_exposure_start_in,
  output logic safe_to_start_out,
  output logic [3:0] out_port
);
  localparam int LAG = `ETC_LAG_CYC < 1 ? 1 : `ETC_LAG_CYC;

  logic [31:0] ctrl_r;
  logic single_r, repeat_r, used_r;
  logic [31:0] shut_r;
  logic aw_r, w_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [3:0] sync1_r, sync2_r;
  logic trig_prev_r;
  etc_exp_t st_r;
  logic pol_lat_r;
  logic [31:0] exp_cnt_r;
  logic [31:0] ro_cnt_r, tx_cnt_r;
  logic ro_busy_r, tx_busy_r, tx_single_r;
  logic exp_active_r;
  logic [7:0] lag_r;
  logic exp_out_r;
  logic ready_r;
  logic [3:0] port_r;

  // synchroniser: second stage is the only reader of the first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end
    else
    begin
      sync1_r <= ext_exposure_start_in; // R21
      sync2_r <= sync1_r; // R21
    end
  end

  wire [1:0] src_sel = ctrl_r[`ETC_B_SRC +: 2];
  wire trig_lvl = sync2_r[src_sel]; // R4
  wire pol = ctrl_r[`ETC_B_POL];
  wire rise = trig_lvl & ~trig_prev_r;
  wire fall = ~trig_lvl & trig_prev_r;
  wire act_edge = pol ? rise : fall; // R2
  // a spent single arm stays set until its image is sent, so gate it by the used flag
  wire armed = (single_r & ~used_r) | repeat_r; // R6 R7
  wire start = ctrl_r[`ETC_B_EN] & armed & ready_r & act_edge & (st_r == ETC_IDLE); // R1 R20
  wire shut_done = exp_cnt_r >= shut_r;
  // level mode ends at opposite edge but never before shutter minimum
  wire opp_low = pol_lat_r ? ~trig_lvl : trig_lvl;
  wire exp_end = (st_r == ETC_PROG && shut_done) ||
                 (st_r == ETC_LEVEL && shut_done && opp_low); // R12 R18
  wire ro_done = ro_busy_r && ro_cnt_r == 32'(READOUT_CYC - 1);
  wire tx_done = tx_busy_r && tx_cnt_r == 32'(XMIT_CYC - 1);
  // overlap: next exposure may start once its shutter time outlasts the readout left
  wire ro_clear = !ro_busy_r || ({1'b0, ro_cnt_r} + {1'b0, shut_r} >= 33'(READOUT_CYC));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trig_prev_r <= 1'b0;
    else
      trig_prev_r <= trig_lvl;
  end

  // exposure engine; style and polarity latched at start only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= ETC_IDLE;
      pol_lat_r <= 1'b1;
      exp_cnt_r <= 32'h0;
    end
    else
    begin
      case (st_r)
        ETC_IDLE:
        begin
          exp_cnt_r <= 32'h1;
          if (start)
          begin
            st_r <= ctrl_r[`ETC_B_STYLE] ? ETC_LEVEL : ETC_PROG; // R3 R22
            pol_lat_r <= pol; // R22
          end
        end
        ETC_PROG, ETC_LEVEL:
        begin
          if (!shut_done)
            exp_cnt_r <= exp_cnt_r + 32'h1;
          if (exp_end)
            st_r <= ETC_IDLE;
        end
        default: st_r <= ETC_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      exp_active_r <= 1'b0;
    else if (start)
      exp_active_r <= 1'b1;
    else if (exp_end)
      exp_active_r <= 1'b0;
  end

  // readout and transmission run beside the next exposure
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ro_busy_r <= 1'b0;
      ro_cnt_r <= 32'h0;
    end
    else if (exp_end)
    begin
      ro_busy_r <= 1'b1; // R12 R16
      ro_cnt_r <= 32'h0;
    end
    else if (ro_done)
      ro_busy_r <= 1'b0;
    else if (ro_busy_r)
      ro_cnt_r <= ro_cnt_r + 32'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_busy_r <= 1'b0;
      tx_cnt_r <= 32'h0;
      tx_single_r <= 1'b0;
    end
    else if (ro_done)
    begin
      tx_busy_r <= 1'b1;
      tx_cnt_r <= 32'h0;
      tx_single_r <= single_r;
    end
    else if (tx_done)
      tx_busy_r <= 1'b0;
    else if (tx_busy_r)
      tx_cnt_r <= tx_cnt_r + 32'h1;
  end

  // ready low from start until exposure over and readout no longer blocks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ready_r <= 1'b0;
    else if (start)
      ready_r <= 1'b0; // R19
    else
      ready_r <= (st_r == ETC_IDLE) && !exp_end && ro_clear; // R19 R16
  end

  // exposure-active delayed by a fixed lag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lag_r <= 8'h0;
      exp_out_r <= 1'b0;
    end
    else
    begin
      lag_r <= {lag_r[6:0], exp_active_r};
      exp_out_r <= lag_r[LAG - 1]; // R13 R17
    end
  end

  wire [1:0] omap = ctrl_r[`ETC_B_OMAP +: 2];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port_r <= 4'h0;
    else
      port_r <= 4'(exp_out_r) << omap; // R14 R15
  end

  // axi4-lite write path
  wire do_wr = aw_r & w_r & ~bvalid;
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[i*8 +: 8] = n[i*8 +: 8];
    return r;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (do_wr)
      begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr_r == `ETC_OFS_STAT) ? 2'b10 : 2'b00;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end
  assign awready = ~aw_r & ~bvalid;
  assign wready = ~w_r & ~bvalid;

  wire wr_ctrl = do_wr && aw_addr_r == `ETC_OFS_CTRL;
  wire wr_arm = do_wr && aw_addr_r == `ETC_OFS_ARM && w_strb_r[0];
  wire wr_shut = do_wr && aw_addr_r == `ETC_OFS_SHUT;
  wire [31:0] ctrl_new = merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_0337;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= `ETC_CTRL_RST; // R5 R14
      shut_r <= `ETC_SHUT_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= ctrl_new; // R15
      if (wr_shut)
        shut_r <= merge(shut_r, w_data_r, w_strb_r);
    end
  end

  // single arm: write wins over the self clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      single_r <= 1'b0;
      repeat_r <= 1'b0;
    end
    else
    begin
      if (wr_arm)
        single_r <= w_data_r[`ETC_B_SINGLE];
      else if (tx_done && tx_single_r)
        single_r <= 1'b0; // R8 R7
      if (wr_arm)
        repeat_r <= w_data_r[`ETC_B_REPEAT]; // R9 R10
    end
  end

  // one-shot: after its start the single arm must not retrigger
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      used_r <= 1'b0;
    else if (wr_arm)
      used_r <= 1'b0;
    else if (start && !repeat_r)
      used_r <= 1'b1; // R7
  end

  // axi4-lite read path
  wire [31:0] stat_w = {26'h0, tx_busy_r, ro_busy_r, exp_active_r, ready_r, used_r, trig_lvl};
  wire [31:0] rd_mux = araddr == `ETC_OFS_CTRL ? ctrl_r :
                       araddr == `ETC_OFS_ARM ? {30'h0, repeat_r, single_r} :
                       araddr == `ETC_OFS_SHUT ? shut_r :
                       araddr == `ETC_OFS_STAT ? stat_w : 32'h0;
  wire rd_ok = araddr == `ETC_OFS_CTRL || araddr == `ETC_OFS_ARM ||
               araddr == `ETC_OFS_SHUT || araddr == `ETC_OFS_STAT;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'b00;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end
  assign arready = ~rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      safe_to_start_out <= 1'b0;
    else
      safe_to_start_out <= ready_r & ctrl_r[`ETC_B_EN]; // R11 R19
  end
  assign out_port = port_r;

  sequence s_start;
    start;
  endsequence
  chk_ready_falls: assert property (@(posedge aclk) disable iff (!aresetn)
    s_start |=> !ready_r) else $error("ready not low after start"); // R19
  chk_no_start_unready: assert property (@(posedge aclk) disable iff (!aresetn)
    start |-> ready_r && ctrl_r[`ETC_B_EN]) else $error("start while unready"); // R20
  chk_prog_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ETC_PROG && exp_end) |-> exp_cnt_r >= shut_r) else $error("short exposure"); // R12
  chk_armed_start: assert property (@(posedge aclk) disable iff (!aresetn)
    start |-> (single_r || repeat_r)) else $error("start unarmed"); // R6
  chk_readout_go: assert property (@(posedge aclk) disable iff (!aresetn)
    exp_end |=> ro_busy_r && ro_cnt_r == 0) else $error("no readout"); // R12
  chk_end_after_readout: assert property (@(posedge aclk) disable iff (!aresetn)
    exp_end |-> !ro_busy_r || ro_done) else $error("exposure ended over readout"); // R16
  chk_active_lag: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(exp_active_r) |-> ##(LAG+1) exp_out_r) else $error("active lag"); // R17
  chk_level_min: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ETC_LEVEL && !shut_done) |=> st_r == ETC_LEVEL) else $error("level short"); // R18
  chk_port_map: assert property (@(posedge aclk) disable iff (!aresetn)
    port_r != 4'h0 |-> port_r == (4'h1 << $past(omap))) else $error("port map"); // R15
endmodule
`default_nettype wire

/* tb/etc_trig_src.sv */
// trigger source model that waits for ready before launching an edge
`timescale 1ns/1ps
`default_nettype none
module etc_trig_src
(
  input wire logic aclk,
  input wire logic safe_to_start_out,
  input wire logic guard,
  input wire logic [1:0] sel,
  input wire logic level,
  output logic [3:0] pins
);
  initial pins = 4'h0;
  // unselected pins are cleared only when the selected pin next changes; guard off only for setup, for the edge sent while disabled and for ending a level exposure
  always @(posedge aclk)
  begin
    if (pins[sel] != level && (safe_to_start_out || !guard))
      pins <= level ? (4'h1 << sel) : 4'h0;
  end
endmodule
`default_nettype wire

/* tb/exposure_trigger_control_test.sv */
// self-checking bench for exposure trigger control
`timescale 1ns/1ps
`default_nettype none
`include "etc_params.svh"
module exposure_trigger_control_test;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, safe_to_start_out;
  logic [3:0] awaddr, araddr, wstrb, out_port, pins;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, sel;
  logic guard, level, prev;
  int n_errors, n_compared, n_exp, i, s, e0;
  etc_top #(.READOUT_CYC(10), .XMIT_CYC(10)) dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .ext_exposure_start_in(pins),
    .safe_to_start_out(safe_to_start_out), .out_port(out_port));
  etc_trig_src src (.aclk(aclk), .safe_to_start_out(safe_to_start_out), .guard(guard),
    .sel(sel), .level(level), .pins(pins));
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    prev <= |out_port;
    if (|out_port && !prev)
      n_exp++;
  end
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hung;
    n_errors++;
    report_and_stop();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    if (k == 50)
      hung();
    bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    if (k == 50)
      hung();
    rready <= 1'b0;
    check("rdata", exp, rdata);
  endtask
  task automatic drive(input logic g, input logic l);
    @(posedge aclk);
    guard <= g;
    level <= l;
    repeat (6) @(posedge aclk);
  endtask
  // width measured at the output so the fixed lag cancels out
  task automatic expo(input int b, input int w);
    int k, n;
    n = 0;
    for (k = 0; k < 300 && out_port[b] !== 1'b1; k++)
      @(posedge aclk);
    if (k == 300)
      hung();
    check("safe_to_start_out", 0, safe_to_start_out);
    while (out_port[b] === 1'b1 && n < 5000)
    begin
      @(posedge aclk);
      n++;
    end
    check("width ok", 1, n >= w && n <= w + 1);
    for (k = 0; k < 500 && !safe_to_start_out; k++)
      @(posedge aclk);
    check("safe_to_start_out", 1, safe_to_start_out);
  endtask
  task automatic no_expo;
    e0 = n_exp;
    repeat (60) @(posedge aclk);
    check("no exposure", e0, n_exp);
  endtask
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, guard, level} = 8'h00;
    {awaddr, araddr, wdata, sel} = '0;
    wstrb = 4'hf;
    n_exp = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ETC_OFS_CTRL, `ETC_CTRL_RST);
    rd(`ETC_OFS_SHUT, `ETC_SHUT_RST);
    check("out_port", 4'h0, out_port);
    wr(`ETC_OFS_ARM, 32'h2, 2'b00);
    drive(1'b0, 1'b1);
    no_expo();
    check("safe_to_start_out", 0, safe_to_start_out);
    wr(`ETC_OFS_SHUT, 32'h6, 2'b00);
    for (s = 0; s < 4; s++)
    begin
      sel <= s[1:0];
      drive(1'b0, 1'b0);
      wr(`ETC_OFS_CTRL, 32'h3 | (s << 4) | (s << 8), 2'b00);
      drive(1'b1, 1'b1);
      expo(s, 6);
    end
    sel <= 2'd0;
    wr(`ETC_OFS_CTRL, 32'h1, 2'b00);
    drive(1'b1, 1'b0);
    expo(0, 6);
    wr(`ETC_OFS_CTRL, 32'h7, 2'b00);
    fork
      expo(0, 40);
      begin
        drive(1'b1, 1'b1);
        repeat (34) @(posedge aclk);
        drive(1'b0, 1'b0);
      end
    join
    // short level pulse: shutter minimum must stretch it
    fork
      expo(0, 6);
      begin
        guard <= 1'b1;
        level <= 1'b1;
        for (i = 0; i < 300 && !pins[0]; i++)
          @(posedge aclk);
        if (i == 300)
          hung();
        guard <= 1'b0;
        level <= 1'b0;
      end
    join
    drive(1'b0, 1'b0);
    wr(`ETC_OFS_CTRL, 32'h3, 2'b00);
    wr(`ETC_OFS_SHUT, 32'h1e, 2'b00);
    fork
      expo(0, 30);
      begin
        drive(1'b1, 1'b1);
        wr(`ETC_OFS_CTRL, 32'h7, 2'b00);
      end
    join
    drive(1'b0, 1'b0);
    wr(`ETC_OFS_CTRL, 32'h3, 2'b00);
    wr(`ETC_OFS_ARM, 32'h1, 2'b00);
    e0 = n_exp;
    drive(1'b1, 1'b1);
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b1);
    repeat (200) @(posedge aclk);
    check("single", e0 + 1, n_exp);
    rd(`ETC_OFS_ARM, 32'h0);
    wr(`ETC_OFS_ARM, 32'h2, 2'b00);
    wr(`ETC_OFS_ARM, 32'h0, 2'b00);
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b1);
    no_expo();
    wr(`ETC_OFS_STAT, 32'h0, 2'b10);
    report_and_stop();
  end
  initial
  begin
    repeat (60000) @(posedge aclk);
    hung();
  end
endmodule
`default_nettype wire
